// ===== pafo_top.sv
// port alternate-function override for the spi/timer, memory-address
// and timer-input/usart-clock pin groups
// assumes all inputs synchronous to clk_i; outputs registered one cycle
`timescale 1ns/1ps
`default_nettype none
`include "pafo_params.svh"
module pafo_top
   import pafo_pkg::*;
(
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   input  wire pafo_port_s portb_i,
   input  wire pafo_port_s portc_i,
   input  wire pafo_port_s portd_i,
   input  wire logic       global_pullup_disable_i,
   input  wire logic       serial_periph_enable_i,
   input  wire logic       serial_master_select_i,
   input  wire logic       spi_master_out_i,
   input  wire logic       spi_slave_out_i,
   input  wire logic       spi_clock_out_i,
   input  wire logic [7:0] pin_change_mask_i,
   input  wire logic       pin_change_group0_enable_i,
   input  wire logic       timer0_compare_a_en_i,
   input  wire logic       timer0_compare_a_out_i,
   input  wire logic       timer1_compare_a_en_i,
   input  wire logic       timer1_compare_a_out_i,
   input  wire logic       timer1_compare_b_en_i,
   input  wire logic       timer1_compare_b_out_i,
   input  wire logic       timer1_compare_c_en_i,
   input  wire logic       timer1_compare_c_out_i,
   input  wire logic       timer2_compare_a_en_i,
   input  wire logic       timer2_compare_a_out_i,
   input  wire logic       ext_memory_enable_i,
   input  wire logic [2:0] ext_memory_high_mask_i,
   input  wire logic [7:0] ext_memory_addr_hi_i,
   input  wire logic       usart_sync_mode_i,
   input  wire logic       usart_clock_out_i,
   output logic [7:0]      portb_oe_o,
   output logic [7:0]      portb_val_o,
   output logic [7:0]      portb_pu_o,
   output logic [7:0]      portb_die_o,
   output logic [7:0]      portc_oe_o,
   output logic [7:0]      portc_val_o,
   output logic [7:0]      portc_pu_o,
   output logic [7:0]      portd_oe_o,
   output logic [7:0]      portd_val_o,
   output logic [7:0]      portd_pu_o,
   output logic [7:0]      pin_change_src_o,
   output logic            spi_master_in_o,
   output logic            spi_slave_in_o,
   output logic            spi_clock_in_o,
   output logic            spi_select_in_o,
   output logic            spi_slave_active_o,
   output logic            timer0_ext_clock_in_o,
   output logic            timer1_ext_clock_in_o,
   output logic            timer1_capture_in_o,
   output logic            usart_sync_clock_in_o
);
   // ------------------------------------------------------------
   // spi role
   // ------------------------------------------------------------
   pafo_role_e role_w;
   assign role_w = !serial_periph_enable_i ? PAFO_ROLE_OFF :
                   serial_master_select_i  ? PAFO_ROLE_MASTER :
                                             PAFO_ROLE_SLAVE;
   wire logic is_mst_w;
   wire logic is_slv_w;
   assign is_mst_w = (role_w == PAFO_ROLE_MASTER);
   assign is_slv_w = (role_w == PAFO_ROLE_SLAVE);

   // ------------------------------------------------------------
   // group 0 overrides
   // ------------------------------------------------------------
   // master: miso forced in; slave: mosi, sck, ss forced in
   wire logic [3:0] spi_force_in_w;
   assign spi_force_in_w = {is_mst_w, is_slv_w, is_slv_w, is_slv_w};
   wire logic [7:0] b_in_force_w;
   assign b_in_force_w = {4'h0, spi_force_in_w};
   wire logic [7:0] b_val_take_w;
   wire logic [7:0] b_pvov_w;
   // value override follows the spi function whenever enabled
   // compare outputs only touch value; direction stays with software
   assign b_val_take_w = {timer0_compare_a_en_i | timer1_compare_c_en_i,
                          timer1_compare_b_en_i,
                          timer1_compare_a_en_i,
                          timer2_compare_a_en_i,
                          is_slv_w, is_mst_w, is_mst_w, 1'h0};
   assign b_pvov_w = {timer0_compare_a_out_i | timer1_compare_c_out_i,
                      timer1_compare_b_out_i,
                      timer1_compare_a_out_i,
                      timer2_compare_a_out_i,
                      spi_slave_out_i,
                      spi_master_out_i,
                      spi_clock_out_i,
                      1'b0};
   // forced-input pins take the port-bit pull-up, cleared by the global disable
   wire logic [7:0] b_puov_w;
   assign b_puov_w = portb_i.out & {8{~global_pullup_disable_i}};
   wire logic [7:0] b_buf_on_w;
   assign b_buf_on_w = pin_change_mask_i
                       & {8{pin_change_group0_enable_i}};
   pafo_pad_s pad_b_w;
   pafo_pad u_pad_b (
      .dir_i                          (portb_i.dir),
      .out_i                          (portb_i.out),
      .global_pullup_disable_i        (global_pullup_disable_i),
      .pullup_override_enable_i       (b_in_force_w),
      .puov_i                         (b_puov_w),
      .direction_override_enable_i    (b_in_force_w),
      .ddov_i                         (8'h00),
      .value_override_enable_i        (b_val_take_w),
      .pvov_i                         (b_pvov_w),
      .input_buffer_override_enable_i (b_buf_on_w),
      .pad_o                          (pad_b_w)
   );

   // ------------------------------------------------------------
   // group 1: high address byte
   // ------------------------------------------------------------
   function automatic logic [7:0] addr_take(input logic [2:0] m);
      logic [7:0] t;
      t = 8'h00;
      t[7] = (m < 3'h1);
      t[6] = (m < 3'h2);
      t[5] = (m < 3'h3);
      t[4] = (m < 3'h4);
      t[3] = (m < 3'h5);
      t[2] = (m < 3'h6);
      t[1] = (m < 3'h7);
      t[0] = (m < 3'h7);
      return t;
   endfunction
   wire logic [7:0] c_ov_w;
   assign c_ov_w = {8{ext_memory_enable_i}}
                   & addr_take(ext_memory_high_mask_i);
   pafo_pad_s pad_c_w;
   pafo_pad u_pad_c (
      .dir_i                          (portc_i.dir),
      .out_i                          (portc_i.out),
      .global_pullup_disable_i        (global_pullup_disable_i),
      .pullup_override_enable_i       (c_ov_w),
      .puov_i                         (8'h00),
      .direction_override_enable_i    (c_ov_w),
      .ddov_i                         (8'hff),
      .value_override_enable_i        (c_ov_w),
      .pvov_i                         (ext_memory_addr_hi_i),
      .input_buffer_override_enable_i (8'h00),
      .pad_o                          (pad_c_w)
   );

   // ------------------------------------------------------------
   // group 2: timer inputs and usart clock
   // ------------------------------------------------------------
   wire logic xck_oe_w;
   assign xck_oe_w = usart_sync_mode_i
                     & portd_i.dir[`PAFO_BIT_XCK];
   wire logic [7:0] d_ov_w;
   assign d_ov_w = {2'h0, xck_oe_w, 5'h00};
   wire logic [7:0] d_val_w;
   assign d_val_w = {2'h0, usart_clock_out_i, 5'h00};
   pafo_pad_s pad_d_w;
   pafo_pad u_pad_d (
      .dir_i                          (portd_i.dir),
      .out_i                          (portd_i.out),
      .global_pullup_disable_i        (global_pullup_disable_i),
      .pullup_override_enable_i       (8'h00),
      .puov_i                         (8'h00),
      .direction_override_enable_i    (d_ov_w),
      .ddov_i                         (8'hff),
      .value_override_enable_i        (d_ov_w),
      .pvov_i                         (d_val_w),
      .input_buffer_override_enable_i (8'h00),
      .pad_o                          (pad_d_w)
   );

   // ------------------------------------------------------------
   // input routing
   // ------------------------------------------------------------
   wire logic sel_w;
   assign sel_w = portb_i.pin[`PAFO_BIT_SS];
   // role split of the two data pins
   wire logic mst_in_w;
   wire logic slv_in_w;
   assign mst_in_w = is_mst_w & portb_i.pin[`PAFO_BIT_MISO];
   assign slv_in_w = is_slv_w & portb_i.pin[`PAFO_BIT_MOSI];
   wire logic xck_in_w;
   // in sync slave-clock mode the pin is the clock input; else idle low
   assign xck_in_w = usart_sync_mode_i & ~portd_i.dir[`PAFO_BIT_XCK]
                     & portd_i.pin[`PAFO_BIT_XCK];

   // ------------------------------------------------------------
   // output registers
   // ------------------------------------------------------------
   always_ff @(posedge clk_i) begin
      if (sys_rst_i) begin
         portb_oe_o <= `PAFO_RST_BYTE;
         portb_val_o <= `PAFO_RST_BYTE;
         portb_pu_o <= `PAFO_RST_BYTE;
         portb_die_o <= `PAFO_RST_BYTE;
         portc_oe_o <= `PAFO_RST_BYTE;
         portc_val_o <= `PAFO_RST_BYTE;
         portc_pu_o <= `PAFO_RST_BYTE;
         portd_oe_o <= `PAFO_RST_BYTE;
         portd_val_o <= `PAFO_RST_BYTE;
         portd_pu_o <= `PAFO_RST_BYTE;
         pin_change_src_o <= `PAFO_RST_BYTE;
         spi_master_in_o <= `PAFO_RST_BIT;
         spi_slave_in_o <= `PAFO_RST_BIT;
         spi_clock_in_o <= `PAFO_RST_BIT;
         spi_select_in_o <= `PAFO_RST_SEL;
         spi_slave_active_o <= `PAFO_RST_BIT;
         timer0_ext_clock_in_o <= `PAFO_RST_BIT;
         timer1_ext_clock_in_o <= `PAFO_RST_BIT;
         timer1_capture_in_o <= `PAFO_RST_BIT;
         usart_sync_clock_in_o <= `PAFO_RST_BIT;
      end else begin
         portb_oe_o <= pad_b_w.oe;
         portb_val_o <= pad_b_w.val;
         portb_pu_o <= pad_b_w.pu;
         portb_die_o <= pad_b_w.die;
         portc_oe_o <= pad_c_w.oe;
         portc_val_o <= pad_c_w.val;
         portc_pu_o <= pad_c_w.pu;
         portd_oe_o <= pad_d_w.oe;
         portd_val_o <= pad_d_w.val;
         portd_pu_o <= pad_d_w.pu;
         pin_change_src_o <= portb_i.pin;
         spi_master_in_o <= mst_in_w;
         spi_slave_in_o <= slv_in_w;
         spi_clock_in_o <= is_slv_w & portb_i.pin[`PAFO_BIT_SCK];
         spi_select_in_o <= is_slv_w ? sel_w : 1'b1;
         spi_slave_active_o <= is_slv_w & ~sel_w;
         timer0_ext_clock_in_o <= portd_i.pin[`PAFO_BIT_TMR0_CLK];
         timer1_ext_clock_in_o <= portd_i.pin[`PAFO_BIT_TMR1_CLK];
         timer1_capture_in_o <= portd_i.pin[`PAFO_BIT_ICP];
         usart_sync_clock_in_o <= xck_in_w;
      end
   end

   // ------------------------------------------------------------
   // assertions
   // ------------------------------------------------------------
   property p_miso_in;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_mst_w |=> !portb_oe_o[`PAFO_BIT_MISO];
   endproperty
   a_miso_in: assert property (p_miso_in)
      else $error("miso driven as master");
   property p_miso_slv;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_slv_w |=> portb_oe_o[3] == $past(portb_i.dir[3])
                   && portb_val_o[3] == $past(spi_slave_out_i);
   endproperty
   a_miso_slv: assert property (p_miso_slv)
      else $error("miso slave drive wrong");
   property p_pu_forced;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_slv_w |=> portb_pu_o[0] == $past(portb_i.out[0]
                   & ~global_pullup_disable_i);
   endproperty
   a_pu_forced: assert property (p_pu_forced)
      else $error("forced input pull-up wrong");
   property p_mosi_in;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_slv_w |=> !portb_oe_o[2] && spi_slave_in_o == $past(portb_i.pin[2]);
   endproperty
   a_mosi_in: assert property (p_mosi_in)
      else $error("mosi slave input wrong");
   property p_mosi_mst;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_mst_w |=> portb_val_o[2] == $past(spi_master_out_i);
   endproperty
   a_mosi_mst: assert property (p_mosi_mst)
      else $error("mosi master value wrong");
   property p_slave_act;
      @(posedge clk_i) disable iff (sys_rst_i)
      spi_slave_active_o |-> $past(is_slv_w) && !$past(sel_w);
   endproperty
   a_slave_act: assert property (p_slave_act)
      else $error("slave active without select");
   property p_addr15;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ext_memory_enable_i && ext_memory_high_mask_i == 3'h0)
      |=> portc_oe_o[7] && !portc_pu_o[7];
   endproperty
   a_addr15: assert property (p_addr15)
      else $error("address bit 15 not driven");
   property p_addr_rel;
      @(posedge clk_i) disable iff (sys_rst_i)
      (ext_memory_enable_i && ext_memory_high_mask_i == 3'h7)
      |=> portc_oe_o == $past(portc_i.dir);
   endproperty
   a_addr_rel: assert property (p_addr_rel)
      else $error("address pins not released");
   property p_xck;
      @(posedge clk_i) disable iff (sys_rst_i)
      !usart_sync_mode_i |=> portd_val_o[5] == $past(portd_i.out[5]);
   endproperty
   a_xck: assert property (p_xck)
      else $error("usart clock pin overridden");
   property p_sck_slv;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_slv_w |=> !portb_oe_o[`PAFO_BIT_SCK]
                   && spi_clock_in_o == $past(portb_i.pin[`PAFO_BIT_SCK]);
   endproperty
   a_sck_slv: assert property (p_sck_slv)
      else $error("clock pin slave input wrong");
   property p_sck_mst;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_mst_w |=> portb_oe_o[1] == $past(portb_i.dir[1])
                   && portb_val_o[1] == $past(spi_clock_out_i);
   endproperty
   a_sck_mst: assert property (p_sck_mst)
      else $error("clock pin master drive wrong");
   property p_ss_slv;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_slv_w |=> !portb_oe_o[0]
                   && spi_select_in_o == $past(portb_i.pin[0]);
   endproperty
   a_ss_slv: assert property (p_ss_slv)
      else $error("select pin slave input wrong");
   property p_ss_mst;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_mst_w |=> portb_oe_o[0] == $past(portb_i.dir[0])
                   && portb_val_o[0] == $past(portb_i.out[0]);
   endproperty
   a_ss_mst: assert property (p_ss_mst)
      else $error("select pin overridden as master");
   property p_split;
      @(posedge clk_i) disable iff (sys_rst_i)
      is_mst_w |=> !spi_slave_in_o
                   && spi_master_in_o == $past(portb_i.pin[3]);
   endproperty
   a_split: assert property (p_split)
      else $error("data pin role split wrong");
   property p_tmr_clk;
      @(posedge clk_i) disable iff (sys_rst_i)
      1'h1 |=> timer0_ext_clock_in_o == $past(portd_i.pin[7])
               && timer1_ext_clock_in_o == $past(portd_i.pin[6]);
   endproperty
   a_tmr_clk: assert property (p_tmr_clk)
      else $error("timer clock input routing wrong");
   property p_xck_out;
      @(posedge clk_i) disable iff (sys_rst_i)
      (usart_sync_mode_i && portd_i.dir[5])
      |=> portd_oe_o[5] && portd_val_o[5] == $past(usart_clock_out_i);
   endproperty
   a_xck_out: assert property (p_xck_out)
      else $error("usart clock pin not driven");
   c_master: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      is_mst_w ##1 is_mst_w);
   c_slave_sel: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      spi_slave_active_o);
   c_mem: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      ext_memory_enable_i ##1 portc_oe_o == 8'hff);
   c_usart: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      usart_sync_mode_i ##1 portd_oe_o[5]);
   c_cmp: cover property (@(posedge clk_i) disable iff (sys_rst_i)
      timer1_compare_b_en_i ##1 portb_val_o[6]);
endmodule
`default_nettype wire

// ===== pafo_params.svh
// constants for the port alternate-function override block
// assumes inclusion by pafo_top, the only module that includes it, guarded below
`ifndef PAFO_PARAMS_SVH
`define PAFO_PARAMS_SVH
`define PAFO_BIT_SS    0
`define PAFO_BIT_SCK   1
`define PAFO_BIT_MOSI  2
`define PAFO_BIT_MISO  3
`define PAFO_BIT_CMP_TMR2A 4
`define PAFO_BIT_CMP_TMR1A 5
`define PAFO_BIT_CMP_TMR1B 6
`define PAFO_BIT_CMP_TMR0A 7
`define PAFO_BIT_TMR0_CLK  7
`define PAFO_BIT_TMR1_CLK  6
`define PAFO_BIT_XCK   5
`define PAFO_BIT_ICP   4
`define PAFO_RST_BYTE  8'h00
`define PAFO_RST_BIT   1'h0
// select input idles high so no slave access is seen in reset
`define PAFO_RST_SEL   1'h1
`endif

// ===== pafo_pkg.sv
// types for the port alternate-function override block
// assumes nothing beyond the params header
package pafo_pkg;
   // one byte-wide port: direction, output and pin level
   typedef struct packed {
      logic [7:0] dir;
      logic [7:0] out;
      logic [7:0] pin;
   } pafo_port_s;
   // resolved pin control for eight pins
   typedef struct packed {
      logic [7:0] oe;
      logic [7:0] val;
      logic [7:0] pu;
      logic [7:0] die;
   } pafo_pad_s;
   typedef enum logic [1:0] {
      PAFO_ROLE_OFF,
      PAFO_ROLE_MASTER,
      PAFO_ROLE_SLAVE
   } pafo_role_e;
endpackage

// ===== pafo_pad.sv
// one generic override cell for eight pins
// assumes override enables and values are combinational from the caller
`timescale 1ns/1ps
`default_nettype none
module pafo_pad
   import pafo_pkg::*;
(
   input  wire logic [7:0] dir_i,
   input  wire logic [7:0] out_i,
   input  wire logic       global_pullup_disable_i,
   input  wire logic [7:0] pullup_override_enable_i,
   input  wire logic [7:0] puov_i,
   input  wire logic [7:0] direction_override_enable_i,
   input  wire logic [7:0] ddov_i,
   input  wire logic [7:0] value_override_enable_i,
   input  wire logic [7:0] pvov_i,
   input  wire logic [7:0] input_buffer_override_enable_i,
   output var  pafo_pad_s  pad_o
);
   // ------------------------------------------------------------
   // override muxes
   // ------------------------------------------------------------
   wire logic [7:0] oe_w;
   wire logic [7:0] val_w;
   wire logic [7:0] pu_norm_w;
   assign oe_w      = (direction_override_enable_i & ddov_i)
                      | (~direction_override_enable_i & dir_i);
   assign val_w     = (value_override_enable_i & pvov_i)
                      | (~value_override_enable_i & out_i);
   // pull-up only ever acts on an input pin
   assign pu_norm_w = out_i & ~dir_i & {8{~global_pullup_disable_i}};
   always_comb begin
      pad_o.oe  = oe_w;
      pad_o.val = val_w;
      pad_o.pu  = (pullup_override_enable_i & puov_i)
                  | (~pullup_override_enable_i & pu_norm_w);
      // input buffer is normally on; override can only force it on
      pad_o.die = input_buffer_override_enable_i | 8'hff;
   end
endmodule
`default_nettype wire

// ===== pafo_pin_model.sv
// far-side model of eight shared pins: external parts and pull-ups
// assumes one instance per port, clocked with the design clock
`timescale 1ns/1ps
`default_nettype none
module pafo_pin_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] val_i,
   input  wire logic [7:0] pu_i,
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output logic [7:0]      pin_o
);
   logic [7:0] float_q;
   // ----------------------------------------------------------------
   // pin resolution
   // ----------------------------------------------------------------
   // a floating pin wanders every cycle so a stale level never passes
   initial float_q = 8'h5a;
   always @(posedge clk_i) begin
      float_q <= ~float_q;
   end
   // external parts drive only where the test enables them
   assign pin_o = (oe_i & val_i)
                | (~oe_i & ext_en_i & ext_val_i)
                | (~oe_i & ~ext_en_i & pu_i)
                | (~oe_i & ~ext_en_i & ~pu_i & float_q);
endmodule
`default_nettype wire

// ===== tb_port_alternate_function_override.sv
// self-checking bench for the pin override block
// assumes pafo_pkg and the pin model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_port_alternate_function_override;
   import pafo_pkg::*;
   logic             clk_i, sys_rst_i, pu_off, spi_on, spi_mst;
   logic             pce, mem_on, usync;
   logic             m_out, s_out, sck_out, uclk;
   logic [9:0]       cmp;
   logic [2:0]       mem_mask;
   logic [7:0]       addr, pcm;
   logic [7:0]       dir [3], out [3], xen [3], xval [3];
   wire  [7:0]       pin [3], oe [3], val [3], pu [3];
   wire  pafo_port_s prt [3];
   wire  [7:0]       die, pcs;
   wire              m_in, s_in, c_in, ss_in, act, t0c, t1c, cap, uin;
   int               fails, num_checks, cyc;
   // ----------------------------------------------------------------
   // design, pins and clock
   // ----------------------------------------------------------------
   for (genvar g = 0; g < 3; g++) begin : g_port
      assign prt[g] = {dir[g], out[g], pin[g]};
      pafo_pin_model u_pafo_pin_model (.clk_i(clk_i), .oe_i(oe[g]),
         .val_i(val[g]), .pu_i(pu[g]), .ext_en_i(xen[g]),
         .ext_val_i(xval[g]), .pin_o(pin[g]));
   end
   pafo_top u_pafo_top (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .portb_i(prt[0]), .portc_i(prt[1]), .portd_i(prt[2]),
      .global_pullup_disable_i(pu_off), .serial_periph_enable_i(spi_on),
      .serial_master_select_i(spi_mst), .spi_master_out_i(m_out),
      .spi_slave_out_i(s_out), .spi_clock_out_i(sck_out),
      .pin_change_mask_i(pcm), .pin_change_group0_enable_i(pce),
      .timer0_compare_a_en_i(cmp[9]), .timer0_compare_a_out_i(cmp[8]),
      .timer1_compare_a_en_i(cmp[7]), .timer1_compare_a_out_i(cmp[6]),
      .timer1_compare_b_en_i(cmp[5]), .timer1_compare_b_out_i(cmp[4]),
      .timer1_compare_c_en_i(cmp[3]), .timer1_compare_c_out_i(cmp[2]),
      .timer2_compare_a_en_i(cmp[1]), .timer2_compare_a_out_i(cmp[0]),
      .ext_memory_enable_i(mem_on), .ext_memory_high_mask_i(mem_mask),
      .ext_memory_addr_hi_i(addr), .usart_sync_mode_i(usync),
      .usart_clock_out_i(uclk), .portb_oe_o(oe[0]), .portb_val_o(val[0]),
      .portb_pu_o(pu[0]), .portb_die_o(die), .portc_oe_o(oe[1]),
      .portc_val_o(val[1]), .portc_pu_o(pu[1]), .portd_oe_o(oe[2]),
      .portd_val_o(val[2]), .portd_pu_o(pu[2]), .pin_change_src_o(pcs),
      .spi_master_in_o(m_in), .spi_slave_in_o(s_in),
      .spi_clock_in_o(c_in), .spi_select_in_o(ss_in),
      .spi_slave_active_o(act), .timer0_ext_clock_in_o(t0c),
      .timer1_ext_clock_in_o(t1c), .timer1_capture_in_o(cap),
      .usart_sync_clock_in_o(uin));
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   // whole run is under a hundred cycles
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 3000) begin
         fails++;
         end_of_test();
      end
   end
   // ----------------------------------------------------------------
   // shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input string nm, input logic [7:0] e,
                      input logic [7:0] g);
      num_checks++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one cycle for the outputs, two more for the pin loop to return
   task automatic nx();
      repeat (3) @(posedge clk_i);
      #1;
   endtask
   function automatic logic [7:0] taken(input int m);
      for (int k = 0; k < 8; k++) begin
         taken[k] = (m < ((k < 2) ? 7 : 8 - k));
      end
   endfunction
   task automatic end_of_test();
      if (fails == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // ----------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------
   task automatic t_idle();
      dir[0] = 8'h0f;
      out[0] = 8'hf5;
      dir[1] = 8'h3c;
      out[1] = 8'hc3;
      nx();
      chk("b_oe", 8'h0f, oe[0]);
      chk("b_val", 8'hf5, val[0]);
      chk("b_pu", 8'hf0, pu[0]);
      chk("c_oe", 8'h3c, oe[1]);
      chk("c_pu", 8'hc3, pu[1]);
      chk("spi_in", 8'h01, {4'h0, m_in, s_in, c_in, ss_in});
      pu_off = 1'b1;
      nx();
      chk("b_pu", 8'h00, pu[0]);
      chk("c_pu", 8'h00, pu[1]);
   endtask
   task automatic t_master();
      pu_off = 1'b0;
      spi_on = 1'b1;
      spi_mst = 1'b1;
      dir[0] = 8'hfb;
      out[0] = 8'h0f;
      m_out = 1'b1;
      xen[0] = 8'h08;
      nx();
      chk("b_oe", 8'hf3, oe[0]);
      chk("b_val", 8'h0d, val[0]);
      chk("b_pu", 8'h0c, pu[0]);
      chk("spi_in", 8'h01, {3'h0, act, m_in, s_in, c_in, ss_in});
      xval[0] = 8'h08;
      m_out = 1'b0;
      sck_out = 1'b1;
      nx();
      chk("b_val", 8'h0b, val[0]);
      chk("m_in", 8'h01, {7'h00, m_in});
   endtask
   task automatic t_slave();
      spi_mst = 1'b0;
      dir[0] = 8'hff;
      out[0] = 8'h0b;
      xen[0] = 8'h07;
      xval[0] = 8'h06;
      nx();
      chk("b_oe", 8'hf8, oe[0]);
      chk("b_val", 8'h03, val[0]);
      chk("b_pu", 8'h03, pu[0]);
      chk("spi_in", 8'h16, {3'h0, act, m_in, s_in, c_in, ss_in});
      xval[0] = 8'h01;
      s_out = 1'b1;
      nx();
      chk("b_val", 8'h0b, val[0]);
      chk("spi_in", 8'h01, {3'h0, act, m_in, s_in, c_in, ss_in});
      pu_off = 1'b1;
      nx();
      chk("b_pu", 8'h00, pu[0]);
   endtask
   task automatic t_pcint();
      spi_on = 1'b0;
      dir[0] = 8'h00;
      xen[0] = 8'hff;
      pcm = 8'hff;
      pce = 1'b1;
      for (int i = 0; i < 2; i++) begin
         xval[0] = i[0] ? 8'h5a : 8'ha5;
         nx();
         chk("pcs", xval[0], pcs);
         chk("die", 8'hff, die);
      end
   endtask
   task automatic t_cmp();
      xen[0] = 8'h00;
      dir[0] = 8'hf0;
      out[0] = 8'h00;
      cmp = 10'h3b2;
      nx();
      chk("b_val", 8'hc0, val[0]);
      chk("b_oe", 8'hf0, oe[0]);
      cmp = 10'h0ef;
      nx();
      chk("b_val", 8'hb0, val[0]);
   endtask
   task automatic t_mem();
      logic [7:0] tk;
      out[1] = 8'hff;
      dir[1] = 8'h00;
      pu_off = 1'b0;
      addr = 8'ha5;
      mem_on = 1'b1;
      for (int m = 0; m < 8; m++) begin
         mem_mask = m[2:0];
         nx();
         tk = taken(m);
         chk("c_oe", tk, oe[1]);
         chk("c_val", (tk & addr) | ~tk, val[1]);
         chk("c_pu", ~tk, pu[1]);
      end
      mem_mask = 3'h0;
      mem_on = 1'b0;
      nx();
      chk("c_oe", 8'h00, oe[1]);
   endtask
   task automatic t_pd();
      dir[2] = 8'h20;
      xen[2] = 8'hd0;
      xval[2] = 8'h90;
      usync = 1'b1;
      uclk = 1'b1;
      nx();
      chk("tmr", 8'h05, {5'h00, t0c, t1c, cap});
      chk("d_oe", 8'h20, oe[2]);
      chk("d_val", 8'h20, val[2]);
      xval[2] = 8'h40;
      nx();
      chk("tmr", 8'h02, {5'h00, t0c, t1c, cap});
      dir[2] = 8'h00;
      xen[2] = 8'hf0;
      xval[2] = 8'h20;
      nx();
      chk("d_oe", 8'h00, oe[2]);
      chk("u_in", 8'h01, {7'h00, uin});
      usync = 1'b0;
      dir[2] = 8'h20;
      xen[2] = 8'hd0;
      nx();
      chk("u_in", 8'h00, {7'h00, uin});
      chk("d_val", 8'h00, val[2]);
      out[2] = 8'h11;
      nx();
      chk("d_pu", 8'h11, pu[2]);
   endtask
   initial begin
      {sys_rst_i, spi_on, spi_mst, pce, mem_on, usync, uclk} = 7'h40;
      {pu_off, m_out, s_out, sck_out} = 4'h0;
      cmp = 10'h000;
      mem_mask = 3'h0;
      addr = 8'h00;
      pcm = 8'h00;
      for (int i = 0; i < 3; i++) begin
         dir[i] = 8'h00;
         out[i] = 8'h00;
         xen[i] = 8'h00;
         xval[i] = 8'h00;
      end
      repeat (20) @(posedge clk_i);
      #1;
      chk("rst", 8'h01, {oe[0][6:0], ss_in});
      sys_rst_i = 1'b0;
      t_idle();
      t_master();
      t_slave();
      t_pcint();
      t_cmp();
      t_mem();
      t_pd();
      end_of_test();
   end
endmodule
`default_nettype wire
